// ---- verilog/serial_port_core.v ----
// serial port core: control register, data buffers, transmitter and receiver
//
// Summary of operation
// [R1] async modes send and receive independently
// [R2] received byte held while next shifts in
// [R3] one data address: write tx, read rx
// [R4] any data buffer write starts transmission
// [R5] software sets port latches for serial pins
// [R6] control register at 98h, resets zero
// [R7] bit 7 is frame error when checking
// [R8] mode 0 clock: sysclk/12, or /4
// [R9] mode 1 check: stop one, address match
// [R10] modes 2/3 check: ninth one, address match
// [R11] transmit done set after last bit
// [R12] receive done set per mode end point
// [R13] mode 0 reception restarts on enable rise
// [R14] modes 1/3: timer 1 overflows /32 or /16
`include "serial_port_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module serial_port_core (
  input  wire       REF_CLK,
  input  wire       NRST,
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire       T1_OVF,
  input  wire       RXD_IN,
  output reg        RXD_OUT,
  output reg        RXD_OE_N,
  output reg        TXD,
  output wire       IRQ
);

  localparam TX_IDLE  = 3'b001;
  localparam TX_ASYNC = 3'b010;
  localparam TX_SYNC  = 3'b100;
  localparam RX_IDLE  = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_DATA  = 4'b0100;
  localparam RX_STOP  = 4'b1000;

  // shared counts as integers, cut to width where they are used
  localparam integer OS_M2     = (`SP_M2_DIV_BIT / `SP_OVERSAMPLE) - 1;
  localparam integer OS_M2_DBL = (`SP_M2_DIV_BIT_DBL / `SP_OVERSAMPLE) - 1;
  localparam integer OS_T1     = (`SP_T1_DIV_BIT / `SP_OVERSAMPLE) - 1;
  localparam integer OS_T1_DBL = (`SP_T1_DIV_BIT_DBL / `SP_OVERSAMPLE) - 1;
  localparam integer M0_SLOW   = (`SP_M0_DIV_CLASSIC / 2) - 1;
  localparam integer M0_FAST   = (`SP_M0_DIV_FAST / 2) - 1;
  localparam integer TICK_MID  = `SP_SAMPLE_MID;
  localparam integer TICK_LAST = `SP_SAMPLE_LAST;
  localparam integer M0_BITS   = `SP_M0_BITS;

  // control register fields, plus aux, receive buffer, address and interrupt registers
  reg       mode0_ff, mode1_ff, mpchk_ff, ren_ff, ren_prev_ff, tb8_ff;
  reg       rb8_ff, tdone_ff, rdone_ff, fe_ff, baud_dbl_ff, frame_chk_ff;
  reg [7:0] rbuf_ff;
  reg [7:0] given_ff;
  reg [7:0] bcast_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_en_ff;

  // engines
  reg [2:0]  tx_state_ff;
  reg [10:0] tx_shift_ff;
  reg [3:0]  tx_bits_ff;
  reg [3:0]  tx_tick_ff;
  reg        m0_rx_ff;
  reg        m0_phase_ff;
  reg [7:0]  m0_rshift_ff;
  reg [3:0]  rx_state_ff;
  reg [3:0]  rx_tick_ff;
  reg [3:0]  rx_bits_ff;
  reg [8:0]  rx_shift_ff;
  reg        rxd_prev_ff;

  wire rxd_s;
  wire os_tick;
  wire m0_half;

  wire wr_ctl  = WR && (ADDR == `SP_ADDR_CONTROL);
  wire wr_data = WR && (ADDR == `SP_ADDR_DATA_BUF);
  wire wr_aux  = WR && (ADDR == `SP_ADDR_AUX_CTRL);

  wire is_m0   = !mode0_ff && !mode1_ff;
  wire is_m1   = !mode0_ff && mode1_ff;
  wire is_m2   = mode0_ff && !mode1_ff;
  wire nine    = mode0_ff;

  serial_sync2 #(
    .RST_VAL (1'b1)
  ) u_rxd_sync (
    .clk   (REF_CLK),
    .rst_n (NRST),
    .d     (RXD_IN),
    .q     (rxd_s)
  );

  // 16x oversample tick: mode 2 from sysclk, modes 1/3 from timer 1
  wire [5:0] os_limit = is_m2 ?
    (baud_dbl_ff ? OS_M2_DBL[5:0] : OS_M2[5:0]) :
    (baud_dbl_ff ? OS_T1_DBL[5:0] : OS_T1[5:0]);                      // [R14]

  serial_pulse_div #(
    .WIDTH (6)
  ) u_os_div (
    .clk     (REF_CLK),
    .rst_n   (NRST),
    .restart (wr_data),  // exact 16-tick start bit; a running receive slips under a tick
    .en      (is_m2 ? 1'b1 : T1_OVF),
    .limit   (os_limit),
    .pulse   (os_tick)
  );

  // mode 0 half-bit pulse, realigned at each start
  wire m0_start_tx = wr_data && is_m0;
  wire m0_start_rx = is_m0 && ren_ff && !ren_prev_ff && !rdone_ff &&
                     (tx_state_ff == TX_IDLE);                        // [R13]
  wire [5:0] m0_limit = mpchk_ff ? M0_FAST[5:0] : M0_SLOW[5:0];       // [R8]

  serial_pulse_div #(
    .WIDTH (6)
  ) u_m0_div (
    .clk     (REF_CLK),
    .rst_n   (NRST),
    .restart (m0_start_tx || m0_start_rx),
    .en      (1'b1),
    .limit   (m0_limit),
    .pulse   (m0_half)
  );

  // hardware events
  reg       tx_done_ev;
  reg       rx_load_ev;
  reg       fe_ev;
  reg [7:0] rx_load_data;
  reg       rx_load_b8;

  wire [7:0] rx_data8 = nine ? rx_shift_ff[7:0] : rx_shift_ff[8:1];
  wire       addr_ok  = (rx_data8 == given_ff) || (rx_data8 == bcast_ff);
  wire       rx_mid   = os_tick &&
                        (rx_tick_ff == ((rx_state_ff == RX_START) ?
                         TICK_MID[3:0] : TICK_LAST[3:0]));

  // completion events of both engines
  always @* begin
    tx_done_ev   = 1'b0;
    rx_load_ev   = 1'b0;
    fe_ev        = 1'b0;
    rx_load_data = rx_data8;
    rx_load_b8   = rxd_s;
    if (tx_state_ff == TX_ASYNC && os_tick && tx_tick_ff == TICK_LAST[3:0] &&
        tx_bits_ff == 4'h1 && !wr_data)
      tx_done_ev = 1'b1;                                              // [R11]
    if (tx_state_ff == TX_SYNC && m0_half && m0_phase_ff &&
        tx_bits_ff == 4'h1) begin
      if (m0_rx_ff) begin
        rx_load_ev   = !rdone_ff;                                     // [R12]
        // all eight bits were captured at the rising shift clock edges
        rx_load_data = m0_rshift_ff;
        rx_load_b8   = rb8_ff;
      end else begin
        tx_done_ev = 1'b1;                                            // [R11]
      end
    end
    if (rx_mid && rx_state_ff == RX_STOP) begin
      fe_ev = !rxd_s;
      // mode 1 ends at the stop bit
      if (is_m1 && !rdone_ff && (!mpchk_ff || (rxd_s && addr_ok)))
        rx_load_ev = 1'b1;                                            // [R9] [R12]
    end
    // modes 2/3 end at the ninth bit, before the stop
    if (rx_mid && rx_state_ff == RX_DATA && nine &&
        rx_bits_ff == 4'h8) begin
      rx_load_data = rx_shift_ff[8:1];
      rx_load_b8   = rxd_s;
      rx_load_ev   = !rdone_ff &&
                     (!mpchk_ff || (rxd_s && (rx_shift_ff[8:1] == given_ff ||
                                              rx_shift_ff[8:1] == bcast_ff))); // [R10] [R12]
    end
  end

  // control, aux and address registers; hardware set wins over write
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      {mode0_ff, mode1_ff, mpchk_ff, ren_ff, tb8_ff, rb8_ff, tdone_ff,
       rdone_ff} <= `SP_CONTROL_RST;                                  // [R6]
      fe_ff        <= 1'b0;
      ren_prev_ff  <= 1'b0;
      baud_dbl_ff  <= 1'b0;
      frame_chk_ff <= 1'b0;
      rbuf_ff      <= `SP_DATA_RST;
      given_ff     <= `SP_ADDR_REG_RST;
      bcast_ff     <= `SP_ADDR_REG_RST;
    end else begin
      ren_prev_ff <= ren_ff;
      if (wr_ctl) begin
        if (frame_chk_ff)
          fe_ff <= WDATA[`SP_CTL_MODE0_FE] || fe_ev;                 // [R7]
        else
          mode0_ff <= WDATA[`SP_CTL_MODE0_FE];
        mode1_ff <= WDATA[`SP_CTL_MODE1];
        mpchk_ff <= WDATA[`SP_CTL_MPCHK];
        ren_ff   <= WDATA[`SP_CTL_REN];
        tb8_ff   <= WDATA[`SP_CTL_TB8];
        rb8_ff   <= rx_load_ev ? rx_load_b8 : WDATA[`SP_CTL_RB8];
        tdone_ff <= WDATA[`SP_CTL_TDONE] || tx_done_ev;
        rdone_ff <= WDATA[`SP_CTL_RDONE] || rx_load_ev;
      end else begin
        if (fe_ev && frame_chk_ff)
          fe_ff <= 1'b1;                                              // [R7]
        if (rx_load_ev)
          rb8_ff <= rx_load_b8;
        if (tx_done_ev)
          tdone_ff <= 1'b1;
        if (rx_load_ev)
          rdone_ff <= 1'b1;
      end
      // holding register only changes on an accepted frame
      if (rx_load_ev)
        rbuf_ff <= rx_load_data;                                      // [R2]
      if (wr_aux) begin
        baud_dbl_ff  <= WDATA[`SP_AUX_BAUD_DBL];
        frame_chk_ff <= WDATA[`SP_AUX_FRAME_CHK];
      end
      if (WR && ADDR == `SP_ADDR_GIVEN)
        given_ff <= WDATA;
      if (WR && ADDR == `SP_ADDR_BROADCAST)
        bcast_ff <= WDATA;
    end
  end

  // interrupt status: sticky, write-one clear, set beats clear
  wire [2:0] irq_set = {fe_ev, tx_done_ev, rx_load_ev};
  wire [2:0] irq_clr = (WR && ADDR == `SP_ADDR_IRQ_CLEAR) ? WDATA[2:0] : 3'h0;

  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_stat_ff <= `SP_IRQ_RST;
      irq_en_ff   <= `SP_IRQ_RST;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      if (WR && ADDR == `SP_ADDR_IRQ_ENABLE)
        irq_en_ff <= WDATA[2:0];
    end
  end

  assign IRQ = |(irq_stat_ff & irq_en_ff);

  // read port: data one cycle after the strobe, zero otherwise
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `SP_ADDR_CONTROL:    RDATA <= {frame_chk_ff ? fe_ff : mode0_ff, mode1_ff,
                                       mpchk_ff, ren_ff, tb8_ff, rb8_ff, tdone_ff,
                                       rdone_ff};                     // [R7]
        `SP_ADDR_DATA_BUF:   RDATA <= rbuf_ff;                        // [R3]
        `SP_ADDR_AUX_CTRL:   RDATA <= {baud_dbl_ff, frame_chk_ff, 6'h00};
        `SP_ADDR_IRQ_STATUS: RDATA <= {5'h00, irq_stat_ff};
        `SP_ADDR_IRQ_ENABLE: RDATA <= {5'h00, irq_en_ff};
        `SP_ADDR_GIVEN:      RDATA <= given_ff;
        `SP_ADDR_BROADCAST:  RDATA <= bcast_ff;
        default:             RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // transmitter; also runs mode 0 reception since that mode shares one pin pair
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_state_ff  <= TX_IDLE;
      tx_shift_ff  <= 11'h7ff;
      tx_bits_ff   <= 4'h0;
      tx_tick_ff   <= 4'h0;
      m0_rx_ff     <= 1'b0;
      m0_phase_ff  <= 1'b0;
      m0_rshift_ff <= 8'h00;
    end else if (wr_data) begin
      // a write always restarts, even mid-frame
      tx_tick_ff  <= 4'h0;                                            // [R4] [R3]
      m0_rx_ff    <= 1'b0;
      m0_phase_ff <= 1'b0;
      if (is_m0) begin
        tx_state_ff <= TX_SYNC;
        tx_shift_ff <= {3'h7, WDATA};
        tx_bits_ff  <= M0_BITS[3:0];
      end else begin
        tx_state_ff <= TX_ASYNC;
        tx_shift_ff <= {1'b1, nine ? tb8_ff : 1'b1, WDATA, 1'b0};
        tx_bits_ff  <= nine ? 4'hb : 4'ha;
      end
    end else begin
      case (tx_state_ff)
        TX_IDLE: begin
          if (m0_start_rx) begin
            tx_state_ff <= TX_SYNC;                                   // [R13]
            m0_rx_ff    <= 1'b1;
            m0_phase_ff <= 1'b0;
            tx_bits_ff  <= M0_BITS[3:0];
          end
        end
        TX_ASYNC: begin
          if (os_tick) begin
            tx_tick_ff <= tx_tick_ff + 4'h1;
            if (tx_tick_ff == TICK_LAST[3:0]) begin
              tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
              tx_bits_ff  <= tx_bits_ff - 4'h1;
              if (tx_bits_ff == 4'h1)
                tx_state_ff <= TX_IDLE;
            end
          end
        end
        TX_SYNC: begin
          if (m0_half) begin
            m0_phase_ff <= !m0_phase_ff;
            // rising shift clock edge: capture; falling: advance
            if (!m0_phase_ff && m0_rx_ff)
              m0_rshift_ff <= {rxd_s, m0_rshift_ff[7:1]};
            if (m0_phase_ff) begin
              tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
              tx_bits_ff  <= tx_bits_ff - 4'h1;
              if (tx_bits_ff == 4'h1)
                tx_state_ff <= TX_IDLE;
            end
          end
        end
        default: tx_state_ff <= TX_IDLE;
      endcase
    end
  end

  // async receiver, independent of the transmitter
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rx_state_ff <= RX_IDLE;
      rx_tick_ff  <= 4'h0;
      rx_bits_ff  <= 4'h0;
      rx_shift_ff <= 9'h000;
      rxd_prev_ff <= 1'b1;
    end else begin
      rxd_prev_ff <= rxd_s;
      if (os_tick && rx_state_ff != RX_IDLE)
        rx_tick_ff <= rx_mid ? 4'h0 : rx_tick_ff + 4'h1;
      case (rx_state_ff)
        RX_IDLE: begin
          if (!is_m0 && ren_ff && rxd_prev_ff && !rxd_s) begin
            rx_state_ff <= RX_START;                                  // [R1]
            rx_tick_ff  <= 4'h0;
            rx_bits_ff  <= 4'h0;
          end
        end
        RX_START: begin
          // a start bit high at mid-bit was a glitch
          if (rx_mid)
            rx_state_ff <= rxd_s ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_shift_ff <= {rxd_s, rx_shift_ff[8:1]};
            rx_bits_ff  <= rx_bits_ff + 4'h1;
            if (rx_bits_ff == (nine ? 4'h8 : 4'h7))
              rx_state_ff <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_mid)
            rx_state_ff <= RX_IDLE;
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
      if (is_m0)
        rx_state_ff <= RX_IDLE;
    end
  end

  // pins from flops; mode 0 drives data on the receive pin
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      TXD      <= 1'b1;
      RXD_OUT  <= 1'b1;
      RXD_OE_N <= 1'b1;
    end else begin
      TXD      <= (tx_state_ff == TX_SYNC) ? m0_phase_ff :
                  (tx_state_ff == TX_ASYNC) ? tx_shift_ff[0] : 1'b1;
      RXD_OUT  <= tx_shift_ff[0];
      RXD_OE_N <= !(tx_state_ff == TX_SYNC && !m0_rx_ff);
    end
  end

endmodule // serial_port_core

`default_nettype wire

// ---- verilog/serial_port_consts.vh ----
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// register offsets
`define SP_ADDR_AUX_CTRL   8'h87
`define SP_ADDR_CONTROL    8'h98
`define SP_ADDR_DATA_BUF   8'h99
`define SP_ADDR_IRQ_STATUS 8'ha0
`define SP_ADDR_IRQ_CLEAR  8'ha1
`define SP_ADDR_IRQ_ENABLE 8'ha2
`define SP_ADDR_GIVEN      8'ha9
`define SP_ADDR_BROADCAST  8'hb9

// serial_control fields
`define SP_CTL_MODE0_FE 7
`define SP_CTL_MODE1    6
`define SP_CTL_MPCHK    5
`define SP_CTL_REN      4
`define SP_CTL_TB8      3
`define SP_CTL_RB8      2
`define SP_CTL_TDONE    1
`define SP_CTL_RDONE    0

// aux control fields
`define SP_AUX_BAUD_DBL  7
`define SP_AUX_FRAME_CHK 6

// interrupt status fields
`define SP_IRQ_RX 0
`define SP_IRQ_TX 1
`define SP_IRQ_FE 2

// reset values
`define SP_CONTROL_RST   8'h00
`define SP_DATA_RST      8'h00
`define SP_AUX_RST       8'h00
`define SP_ADDR_REG_RST  8'h00
`define SP_IRQ_RST       3'h0

// mode 0 clocks per bit (12 or 4), halved for the shift clock half period
`define SP_M0_DIV_CLASSIC 12
`define SP_M0_DIV_FAST    4
// mode 2 clocks per bit (64, or 32 doubled) and t1 overflows per bit (32 or 16)
`define SP_M2_DIV_BIT     64
`define SP_M2_DIV_BIT_DBL 32
`define SP_T1_DIV_BIT     32
`define SP_T1_DIV_BIT_DBL 16
// oversampling ticks per bit and mid-bit sample point
`define SP_OVERSAMPLE     16
`define SP_SAMPLE_MID     7
`define SP_SAMPLE_LAST    15
`define SP_M0_BITS        8

`endif

// ---- verilog/serial_sync2.v ----
// two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none

module serial_sync2 #(
  parameter RST_VAL = 1'b1
) (
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output wire q
);

  reg meta_ff;
  reg sync_ff;

  // first stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule // serial_sync2

`default_nettype wire

// ---- verilog/serial_pulse_div.v ----
// pulse divider: one output pulse per limit+1 enable pulses
`timescale 1ns/1ps
`default_nettype none

module serial_pulse_div #(
  parameter WIDTH = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             restart,
  input  wire             en,
  input  wire [WIDTH-1:0] limit,
  output wire             pulse
);

  reg [WIDTH-1:0] cnt_ff;

  assign pulse = en && (cnt_ff >= limit) && !restart;

  // restart realigns the phase so a frame starts a full period out
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cnt_ff <= {WIDTH{1'b0}};
    else if (restart || pulse)
      cnt_ff <= {WIDTH{1'b0}};
    else if (en)
      cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
  end

endmodule // serial_pulse_div

`default_nettype wire

// ---- testbench/serial_port_core_asserts.sv ----
// assertions on the serial port core pins
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.vh"
module serial_port_core_asserts (
  input wire logic       REF_CLK,
  input wire logic       NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       T1_OVF,
  input wire logic       RXD_IN,
  input wire logic       RXD_OUT,
  input wire logic       RXD_OE_N,
  input wire logic       TXD,
  input wire logic       IRQ
);
  logic [1:0] mode_ff;
  logic       mpchk_ff, dbl_ff, fchk_ff, wd0, dwr, m2wr;
  // data buffer write decode, and an undoubled mode 2 start
  assign wd0  = WDATA[0];
  assign dwr  = WR && ADDR == `SP_ADDR_DATA_BUF;
  assign m2wr = dwr && mode_ff == 2'b10 && !dbl_ff;
  // mode shadow; bit 7 is frozen while it serves as the error flag
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      {mode_ff, mpchk_ff, dbl_ff, fchk_ff} <= 5'h00;
    end else if (WR && ADDR == `SP_ADDR_CONTROL) begin
      mode_ff <= {fchk_ff ? mode_ff[1] : WDATA[7], WDATA[6]};
      mpchk_ff <= WDATA[5];
    end else if (WR && ADDR == `SP_ADDR_AUX_CTRL) begin
      {dbl_ff, fchk_ff} <= WDATA[7:6];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside a reply");
  clear_reads_a: assert property (RD && ADDR == `SP_ADDR_IRQ_CLEAR |=> RDATA == 8'h00)
    else $error("clear register read not zero");
  tx_start_a: assert property (dwr && mode_ff != 2'b00 |-> ##2 !TXD)
    else $error("no start bit after data write");
  start_len_a: assert property (m2wr |-> ##65 !TXD ##1 TXD == $past(wd0, 66))
    else $error("mode 2 start bit length wrong");
  m0_drive_a: assert property (!RXD_OE_N |-> mode_ff == 2'b00)
    else $error("receive pin driven outside mode 0");
  m0_slow_a: assert property (mode_ff == 2'b00 && !mpchk_ff && $fell(TXD)
    |-> !TXD[*6] ##1 TXD)
    else $error("mode 0 slow half period wrong");
  m0_fast_a: assert property (mode_ff == 2'b00 && mpchk_ff && $fell(TXD)
    |-> !TXD[*2] ##1 TXD)
    else $error("mode 0 fast half period wrong");
  m0_data_a: assert property (!RXD_OE_N && !TXD && !$fell(TXD) |-> $stable(RXD_OUT))
    else $error("mode 0 data moved in low half");
  irq_mask_a: assert property (WR && ADDR == `SP_ADDR_IRQ_ENABLE && WDATA == 8'h00 |=> !IRQ)
    else $error("interrupt stays up when masked");
endmodule // serial_port_core_asserts
`default_nettype wire

// ---- testbench/serial_remote_node.sv ----
// remote serial node: drives the receive pin, samples the transmit pin
`timescale 1ns/1ps
`default_nettype none
module serial_remote_node (
  input wire logic clk,
  input wire logic txd,
  output var logic rxd
);
  // line pulled up and latch set, so it idles high
  initial rxd = 1'b1;
  // async frame: start, data lsb first, optional ninth, stop
  task automatic send(input logic [7:0] d, input logic b9, input logic nine,
                      input logic stp, input int bc);
    logic [10:0] f;
    f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (bc - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask
  // sample n bits after the start bit, at mid bit
  task automatic grab(input int bc, input int n, output logic [9:0] v);
    v = 10'h000;
    @(negedge txd);
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (bc) @(posedge clk);
      v[i] = txd;
    end
  endtask
  // mode 0: next bit placed once the shift clock has risen
  task automatic m0_feed(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      rxd <= d[i];
      @(posedge txd);
    end
    rxd <= 1'b1;
  endtask
endmodule // serial_remote_node
`default_nettype wire

// ---- testbench/test_serial_port_core.sv ----
// self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.vh"
module test_serial_port_core;
  localparam logic [7:0] ctl_a = `SP_ADDR_CONTROL, buf_a = `SP_ADDR_DATA_BUF;
  localparam logic [7:0] sts_a = `SP_ADDR_IRQ_STATUS, clr_a = `SP_ADDR_IRQ_CLEAR;
  localparam logic [7:0] ena_a = `SP_ADDR_IRQ_ENABLE, aux_a = `SP_ADDR_AUX_CTRL;
  logic       REF_CLK, NRST, WR, RD, T1_OVF, TXD, IRQ, RXD_IN, RXD_OUT, RXD_OE_N;
  logic [7:0] ADDR, WDATA, RDATA, v;
  logic [9:0] f;
  int         fails, checks;
  logic [7:0] mp_d [4] = '{8'h5a, 8'h5a, 8'h11, 8'hff};
  logic [7:0] tx_aux [3] = '{8'h80, 8'h00, 8'h80};
  logic [7:0] tx_ctl [3] = '{8'h58, 8'hd8, 8'hd8};
  int         tx_bc [3] = '{32, 64, 32};
  int         tx_n [3] = '{9, 10, 10};
  serial_port_core serial_port_core_i (.REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .T1_OVF(T1_OVF), .RXD_IN(RXD_IN),
    .RXD_OUT(RXD_OUT), .RXD_OE_N(RXD_OE_N), .TXD(TXD), .IRQ(IRQ));
  serial_remote_node serial_remote_node_i (.clk(REF_CLK), .txd(TXD), .rxd(RXD_IN));
  // 10 MHz clock
  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  // timer overflow every second clock
  always @(posedge REF_CLK) T1_OVF <= ~T1_OVF;
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    {WR, ADDR, WDATA} <= {1'b1, a, d};
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask
  // reply stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge REF_CLK);
    {RD, ADDR} <= {1'b1, a};
    @(posedge REF_CLK);
    RD <= 1'b0;
    @(posedge REF_CLK);
    d = RDATA;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({2'b00, d}, {2'b00, e});
  endtask
  // one frame from the remote node, then let the stop bit pass
  task automatic frame(input logic [7:0] d, input logic b9, input logic nine,
                       input logic stp);
    serial_remote_node_i.send(d, b9, nine, stp, 64);
    repeat (32) @(posedge REF_CLK);
  endtask
  task automatic conclude;
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // the whole run needs some 9000 clocks
  initial begin
    repeat (40000) @(posedge REF_CLK);
    fails++;
    conclude();
  end
  initial begin
    {NRST, WR, RD, ADDR, WDATA, T1_OVF} = '0;
    repeat (10) @(posedge REF_CLK);
    NRST <= 1'b1;
    // reset values, unmapped and read-only places
    rchk(ctl_a, `SP_CONTROL_RST);
    rchk(buf_a, `SP_DATA_RST);
    chk(10'(TXD), 10'h1);
    wr(8'h55, 8'hff);
    wr(sts_a, 8'hff);
    rchk(8'h55, 8'h00);
    rchk(sts_a, 8'h00);
    rchk(clr_a, 8'h00);
    wr(ctl_a, 8'h6c);
    rchk(ctl_a, 8'h6c);
    // mode 2 both directions at once, interrupt raised and masked
    wr(ena_a, 8'h03);
    wr(ctl_a, 8'h98);
    fork
      serial_remote_node_i.grab(64, 10, f);
      wr(buf_a, 8'ha5);
      frame(8'h3c, 1'b1, 1'b1, 1'b1);
    join
    repeat (32) @(posedge REF_CLK);
    chk(f, 10'h3a5);
    rchk(ctl_a, 8'h9f);
    rchk(buf_a, 8'h3c);
    rchk(sts_a, 8'h03);
    chk(10'(IRQ), 10'h1);
    wr(ena_a, 8'h00);
    rchk(sts_a, 8'h03);
    chk(10'(IRQ), 10'h0);
    wr(clr_a, 8'h03);
    rchk(sts_a, 8'h00);
    // second byte shifts in while the first is still held in the buffer
    fork
      frame(8'h81, 1'b0, 1'b1, 1'b1);
      begin
        repeat (300) @(posedge REF_CLK);
        rchk(buf_a, 8'h3c);
        wr(ctl_a, 8'h98);
      end
    join
    rchk(buf_a, 8'h81);
    frame(8'h77, 1'b1, 1'b1, 1'b1);
    rchk(buf_a, 8'h81);
    // address check: ninth bit and a given or broadcast match
    wr(`SP_ADDR_GIVEN, 8'h5a);
    wr(`SP_ADDR_BROADCAST, 8'hff);
    for (int i = 0; i < 4; i++) begin
      wr(ctl_a, 8'hb8);
      frame(mp_d[i], i != 0, 1'b1, 1'b1);
      rd(ctl_a, v);
      chk(10'(v[0]), 10'(i[0]));
    end
    rchk(buf_a, 8'hff);
    // mode 1 low stop bit: taken unchecked, flagged as frame error
    wr(clr_a, 8'h07);
    wr(ctl_a, 8'h50);
    wr(aux_a, 8'h40);
    frame(8'hc3, 1'b0, 1'b0, 1'b0);
    rchk(ctl_a, 8'hd1);
    rchk(buf_a, 8'hc3);
    rchk(sts_a, 8'h05);
    wr(aux_a, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(ctl_a, 8'h70);
      frame(8'h5a, 1'b0, 1'b0, i[0]);
      rd(ctl_a, v);
      chk(10'(v[0]), 10'(i[0]));
    end
    // mode 1 transmits at the doubled timer rate, mode 3 at both
    for (int i = 0; i < 3; i++) begin
      wr(aux_a, tx_aux[i]);
      wr(ctl_a, tx_ctl[i]);
      fork
        serial_remote_node_i.grab(tx_bc[i], tx_n[i], f);
        wr(buf_a, 8'h96);
      join
      repeat (64) @(posedge REF_CLK);
      chk(f, tx_n[i] == 9 ? 10'h196 : 10'h396);
    end
    // mode 0 shifting out at both clock rates
    wr(aux_a, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(ctl_a, i ? 8'h20 : 8'h00);
      fork
        for (int k = 0; k < 8; k++) begin
          @(posedge TXD);
          v[k] = RXD_OUT;
        end
        wr(buf_a, 8'hc5);
      join
      repeat (16) @(posedge REF_CLK);
      chk({2'b00, v}, 10'h0c5);
      rchk(ctl_a, i ? 8'h22 : 8'h02);
    end
    // mode 0 reception started by a rise of the enable bit
    wr(ctl_a, 8'h00);
    fork
      serial_remote_node_i.m0_feed(8'h6b);
      wr(ctl_a, 8'h10);
    join
    repeat (16) @(posedge REF_CLK);
    rchk(ctl_a, 8'h11);
    rchk(buf_a, 8'h6b);
    conclude();
  end
endmodule // test_serial_port_core
bind serial_port_core serial_port_core_asserts serial_port_core_asserts_i (
  .REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .T1_OVF(T1_OVF), .RXD_IN(RXD_IN), .RXD_OUT(RXD_OUT),
  .RXD_OE_N(RXD_OE_N), .TXD(TXD), .IRQ(IRQ));
`default_nettype wire
